/* File: shared/tat_pkg.sv */
package tat_pkg;
// Contract
// - buffer holds exactly 48 entries; every mapped address is looked up
// - each entry maps an even and an odd page, 96 pages in all
// - physical address is 36 bits; frame number gives the upper bits
// - page size 4 KB to 16 MB through a per-entry compare mask
// - high word: page pair number 31:13, zeros 12:8, space id 7:0
// - entry hits only when its 8-bit space id equals the current id or it is global
// - global set in both halves makes the lookup ignore the space id
// - selected half not valid gives a miss, translation unused
// - stores need the dirty bit set, else a write protect fault
// - cache attribute of the page goes out with the physical address
// - user space 2 GB in 32-bit mode, 1 TB in 64-bit mode
// - user, supervisor and kernel levels, each with its own regions
// - user level: only the 2 GB mapped region from zero in 32-bit mode
// - supervisor: low 2 GB plus 0.5 GB from 0xc0000000
// - kernel level reaches the whole 4 GB space
// - access to a forbidden region gives an address error

    localparam int TAT_ENTRIES = 48;
    localparam int TAT_PAGES   = 96;
    localparam int TAT_PA_W    = 36;
    localparam int TAT_VA_W    = 40;
    localparam int TAT_IDX_W   = 6;

    localparam logic [7:0] TAT_OFF_HI   = 8'h00;
    localparam logic [7:0] TAT_OFF_LOE  = 8'h04;
    localparam logic [7:0] TAT_OFF_LOO  = 8'h08;
    localparam logic [7:0] TAT_OFF_MASK = 8'h0C;
    localparam logic [7:0] TAT_OFF_IDX  = 8'h10;
    localparam logic [7:0] TAT_OFF_CMD  = 8'h14;
    localparam logic [7:0] TAT_OFF_CTRL = 8'h18;

    localparam int TAT_HI_VIRTUAL_PAGE_PAIR_NUMBER_LSB = 13;
    localparam int TAT_MASK_LSB    = 13;
    localparam int TAT_LO_PFN_LSB  = 6;
    localparam int TAT_LO_C_LSB    = 3;
    localparam int TAT_LO_D        = 2;
    localparam int TAT_LO_V        = 1;
    localparam int TAT_LO_G        = 0;
    localparam int TAT_IDX_FAIL    = 31;

    localparam logic [1:0] TAT_CMD_WR    = 2'h1;
    localparam logic [1:0] TAT_CMD_RD    = 2'h2;
    localparam logic [1:0] TAT_CMD_PROBE = 2'h3;

    localparam logic [2:0] TAT_CCA_UNC   = 3'h2;
    localparam logic [2:0] TAT_CCA_CACHE = 3'h3;
    localparam logic       TAT_ADDR64_RST = 1'b0;

    typedef enum logic [1:0] {TAT_KERNEL, TAT_SUPER, TAT_USER} tat_mode_t;

    typedef struct packed {
        logic [23:0] page_frame_number;
        logic [2:0]  cca;
        logic        d;
        logic        v;
        logic        g;
    } tat_lo_t;

    typedef struct packed {
        logic [11:0] mask;
        logic [18:0] virtual_page_pair_number;
        logic [7:0]  process_space_id;
        tat_lo_t     lo_e;
        tat_lo_t     lo_o;
    } tat_entry_t;

    typedef struct packed {
        logic                valid;
        logic                store;
        tat_mode_t           mode;
        logic [TAT_VA_W-1:0] va;
    } tat_req_t;

    typedef struct packed {
        logic                done;
        logic                ok;
        logic                addr_err;
        logic                miss;
        logic                wprot;
        logic [2:0]          cca;
        logic [TAT_PA_W-1:0] pa;
    } tat_res_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } tat_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } tat_apb_rsp_t;
endpackage : tat_pkg

/* File: design/tat_region.sv */
`timescale 1ns/1ps
module tat_region (
    input  wire tat_pkg::tat_mode_t mode,
    input  wire logic [39:0]        va,
    input  wire logic               addr64,
    output logic                    err,
    output logic                    mapped,
    output logic                    uncached
);
    import tat_pkg::*;
    logic hi_zero;

    always_comb
    begin
        hi_zero  = (va[39:32] == 8'h00);
        err      = 1'b0;
        mapped   = 1'b1;
        uncached = 1'b0;
        case (mode)
            TAT_KERNEL:
            begin
                err = !hi_zero;
                if (va[31:30] == 2'b10)
                begin
                    mapped   = 1'b0;
                    uncached = va[29];
                end
            end
            TAT_SUPER:
                err = !hi_zero || (va[31] && va[31:29] != 3'b110);
            default:
                // odd mode code is treated as user, the safest reading
                err = addr64 ? 1'b0 : (!hi_zero || va[31]);
        endcase
    end
endmodule : tat_region

/* File: design/tat_match.sv */
`timescale 1ns/1ps
module tat_match (
    input  wire tat_pkg::tat_entry_t e,
    input  wire logic [31:12]        va,
    input  wire logic [7:0]          process_space_id,
    output logic                     hit,
    output logic                     odd
);
    import tat_pkg::*;
    logic [18:0] cmp;
    logic [12:0] ext;
    logic [12:0] hsel;

    always_comb
    begin
        cmp  = ~{7'h00, e.mask};
        ext  = {e.mask, 1'b1};
        hsel = ext & ~{1'b0, ext[12:1]};
        hit  = (((va[31:13] ^ e.virtual_page_pair_number) & cmp) == 19'h00000)
            && ((e.process_space_id == process_space_id) || (e.lo_e.g && e.lo_o.g));
        odd  = |(va[24:12] & hsel);
    end
endmodule : tat_match

/* File: design/tat_top.sv */
`timescale 1ns/1ps
module tat_top (
    input  wire logic                  SYS_CLK,
    input  wire logic                  SYS_RST,
    input  wire tat_pkg::tat_apb_req_t APB_REQ,
    output tat_pkg::tat_apb_rsp_t      APB_RSP,
    input  wire tat_pkg::tat_req_t     XLAT_REQ,
    output tat_pkg::tat_res_t          XLAT_RES
);
    import tat_pkg::*;

    typedef struct packed {
        tat_entry_t [TAT_ENTRIES-1:0] ent;
        logic [18:0]                  virtual_page_pair_number;
        logic [7:0]                   process_space_id;
        tat_lo_t                      lo_e;
        tat_lo_t                      lo_o;
        logic [11:0]                  mask;
        logic [5:0]                   idx;
        logic                         pfail;
        logic                         addr64;
        tat_apb_rsp_t                 rsp;
        tat_res_t                     res;
    } tat_state_t;

    tat_state_t s_r;
    tat_state_t s_nxt;

    logic [TAT_ENTRIES-1:0] hit_v;
    logic [TAT_ENTRIES-1:0] odd_v;
    logic [TAT_ENTRIES-1:0] phit_v;
    logic                   r_err;
    logic                   r_mapped;
    logic                   r_unc;

    tat_region u_region (
        .mode     (XLAT_REQ.mode),
        .va       (XLAT_REQ.va),
        .addr64   (s_r.addr64),
        .err      (r_err),
        .mapped   (r_mapped),
        .uncached (r_unc)
    );

    // lookup and probe each get their own comparator bank per entry
    genvar gi;
    generate
        for (gi = 0; gi < TAT_ENTRIES; gi++)
        begin : g_ent
            tat_match u_look (
                .e    (s_r.ent[gi]),
                .va   (XLAT_REQ.va[31:12]),
                .process_space_id (s_r.process_space_id),
                .hit  (hit_v[gi]),
                .odd  (odd_v[gi])
            );
            tat_match u_probe (
                .e    (s_r.ent[gi]),
                .va   ({s_r.virtual_page_pair_number, 1'b0}),
                .process_space_id (s_r.process_space_id),
                .hit  (phit_v[gi]),
                .odd  ()
            );
        end
    endgenerate

    logic        found;
    logic [5:0]  fidx;
    logic        pfound;
    logic [5:0]  pidx;
    tat_entry_t  se;
    tat_lo_t     slo;
    logic [35:0] offm;
    logic [35:0] pa_map;
    logic        setup;
    logic        access;
    logic        known;
    logic [31:0] rd;

    always_comb
    begin
        found  = 1'b0;
        fidx   = 6'h00;
        pfound = 1'b0;
        pidx   = 6'h00;
        // lowest index wins if software left duplicate mappings
        for (int i = 0; i < TAT_ENTRIES; i++)
        begin
            if (hit_v[i] && !found)
            begin
                found = 1'b1;
                fidx  = 6'(i);
            end
            if (phit_v[i] && !pfound)
            begin
                pfound = 1'b1;
                pidx   = 6'(i);
            end
        end
        se     = s_r.ent[fidx];
        slo    = odd_v[fidx] ? se.lo_o : se.lo_e;
        offm   = {12'h000, se.mask, 12'hFFF};
        pa_map = ({slo.page_frame_number, 12'h000} & ~offm)
               | ({12'h000, XLAT_REQ.va[23:0]} & offm);
    end

    always_comb
    begin
        setup  = APB_REQ.psel && !APB_REQ.penable;
        access = APB_REQ.psel && APB_REQ.penable && s_r.rsp.pready;
        known  = 1'b1;
        rd     = 32'h00000000;
        if (APB_REQ.paddr == TAT_OFF_HI)
            rd = {s_r.virtual_page_pair_number, 5'h00, s_r.process_space_id};
        else if (APB_REQ.paddr == TAT_OFF_LOE)
            rd = {2'b00, s_r.lo_e};
        else if (APB_REQ.paddr == TAT_OFF_LOO)
            rd = {2'b00, s_r.lo_o};
        else if (APB_REQ.paddr == TAT_OFF_MASK)
            rd = {7'h00, s_r.mask, 13'h0000};
        else if (APB_REQ.paddr == TAT_OFF_IDX)
            rd = {s_r.pfail, 25'h0000000, s_r.idx};
        else if (APB_REQ.paddr == TAT_OFF_CMD)
            rd = 32'h00000000;
        else if (APB_REQ.paddr == TAT_OFF_CTRL)
            rd = {31'h00000000, s_r.addr64};
        else
            known = 1'b0;
    end

    always_comb
    begin
        s_nxt = s_r;
        // zero wait slave: answer is prepared during setup
        s_nxt.rsp.pready  = setup;
        s_nxt.rsp.pslverr = setup && !known;
        s_nxt.rsp.prdata  = (setup && !APB_REQ.pwrite) ? rd : 32'h00000000;
        if (access && APB_REQ.pwrite)
        begin
            if (APB_REQ.paddr == TAT_OFF_HI)
            begin
                s_nxt.virtual_page_pair_number = APB_REQ.pwdata[31:TAT_HI_VIRTUAL_PAGE_PAIR_NUMBER_LSB];
                s_nxt.process_space_id = APB_REQ.pwdata[7:0];
            end
            else if (APB_REQ.paddr == TAT_OFF_LOE)
                s_nxt.lo_e = APB_REQ.pwdata[29:0];
            else if (APB_REQ.paddr == TAT_OFF_LOO)
                s_nxt.lo_o = APB_REQ.pwdata[29:0];
            else if (APB_REQ.paddr == TAT_OFF_MASK)
                s_nxt.mask = APB_REQ.pwdata[24:TAT_MASK_LSB];
            else if (APB_REQ.paddr == TAT_OFF_IDX)
                s_nxt.idx = APB_REQ.pwdata[5:0];
            else if (APB_REQ.paddr == TAT_OFF_CTRL)
                s_nxt.addr64 = APB_REQ.pwdata[0];
            else if (APB_REQ.paddr == TAT_OFF_CMD)
            begin
                if (APB_REQ.pwdata[1:0] == TAT_CMD_WR)
                begin
                    // out of range index is dropped, not wrapped
                    if (s_r.idx < TAT_ENTRIES)
                    begin
                        s_nxt.ent[s_r.idx].mask = s_r.mask;
                        s_nxt.ent[s_r.idx].virtual_page_pair_number = s_r.virtual_page_pair_number;
                        s_nxt.ent[s_r.idx].process_space_id = s_r.process_space_id;
                        s_nxt.ent[s_r.idx].lo_e = s_r.lo_e;
                        s_nxt.ent[s_r.idx].lo_o = s_r.lo_o;
                    end
                end
                else if (APB_REQ.pwdata[1:0] == TAT_CMD_RD)
                begin
                    if (s_r.idx < TAT_ENTRIES)
                    begin
                        s_nxt.mask = s_r.ent[s_r.idx].mask;
                        s_nxt.virtual_page_pair_number = s_r.ent[s_r.idx].virtual_page_pair_number;
                        s_nxt.process_space_id = s_r.ent[s_r.idx].process_space_id;
                        s_nxt.lo_e = s_r.ent[s_r.idx].lo_e;
                        s_nxt.lo_o = s_r.ent[s_r.idx].lo_o;
                    end
                end
                else if (APB_REQ.pwdata[1:0] == TAT_CMD_PROBE)
                begin
                    s_nxt.pfail = !pfound;
                    if (pfound)
                        s_nxt.idx = pidx;
                end
            end
        end

        s_nxt.res = '0;
        if (XLAT_REQ.valid)
        begin
            s_nxt.res.done = 1'b1;
            if (r_err)
                s_nxt.res.addr_err = 1'b1;
            else if (!r_mapped)
            begin
                s_nxt.res.ok  = 1'b1;
                s_nxt.res.pa  = {7'h00, XLAT_REQ.va[28:0]};
                s_nxt.res.cca = r_unc ? TAT_CCA_UNC : TAT_CCA_CACHE;
            end
            else if (!found || !slo.v)
                s_nxt.res.miss = 1'b1;
            else if (XLAT_REQ.store && !slo.d)
                s_nxt.res.wprot = 1'b1;
            else
            begin
                s_nxt.res.ok  = 1'b1;
                s_nxt.res.pa  = pa_map;
                s_nxt.res.cca = slo.cca;
            end
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            s_r        <= '0;
            s_r.addr64 <= TAT_ADDR64_RST;
        end
        else
            s_r <= s_nxt;
    end

    assign APB_RSP  = s_r.rsp;
    assign XLAT_RES = s_r.res;

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (SYS_RST);

    property p_hi_rsvd;
        APB_RSP.pready && $past(APB_REQ.paddr == TAT_OFF_HI && !APB_REQ.pwrite)
            |-> APB_RSP.prdata[12:8] == 5'h00;
    endproperty
    a_hi_rsvd: assert property (p_hi_rsvd) else $error("reserved bits not zero");

    property p_user_err;
        XLAT_REQ.valid && XLAT_REQ.mode == TAT_USER && !s_r.addr64 && XLAT_REQ.va[31]
            |=> XLAT_RES.addr_err && !XLAT_RES.ok;
    endproperty
    a_user_err: assert property (p_user_err) else $error("user upper half allowed");

    property p_sup_err;
        XLAT_REQ.valid && XLAT_REQ.mode == TAT_SUPER && XLAT_REQ.va[31:29] == 3'b111
            |=> XLAT_RES.addr_err;
    endproperty
    a_sup_err: assert property (p_sup_err) else $error("supervisor top allowed");

    property p_sup_ok;
        XLAT_REQ.valid && XLAT_REQ.mode == TAT_SUPER
            && XLAT_REQ.va[39:29] == {8'h00, 3'b110} |=> !XLAT_RES.addr_err;
    endproperty
    a_sup_ok: assert property (p_sup_ok) else $error("supervisor window refused");

    property p_kern_ok;
        XLAT_REQ.valid && XLAT_REQ.mode == TAT_KERNEL && XLAT_REQ.va[39:32] == 8'h00
            |=> XLAT_RES.done && !XLAT_RES.addr_err;
    endproperty
    a_kern_ok: assert property (p_kern_ok) else $error("kernel access refused");

    property p_kseg;
        XLAT_REQ.valid && XLAT_REQ.mode == TAT_KERNEL
            && XLAT_REQ.va[39:30] == {8'h00, 2'b10}
            |=> XLAT_RES.ok && XLAT_RES.pa == {7'h00, $past(XLAT_REQ.va[28:0])}
            && XLAT_RES.cca == ($past(XLAT_REQ.va[29]) ? TAT_CCA_UNC : TAT_CCA_CACHE);
    endproperty
    a_kseg: assert property (p_kseg) else $error("unmapped window wrong");

    property p_one;
        XLAT_REQ.valid |=> XLAT_RES.done
            && $onehot({XLAT_RES.ok, XLAT_RES.addr_err, XLAT_RES.miss, XLAT_RES.wprot});
    endproperty
    a_one: assert property (p_one) else $error("lookup answer not single");

    property p_wprot;
        XLAT_RES.wprot |-> $past(XLAT_REQ.valid && XLAT_REQ.store);
    endproperty
    a_wprot: assert property (p_wprot) else $error("protect fault on load");

    property p_miss;
        XLAT_RES.miss |-> XLAT_RES.pa == 36'h000000000 && !XLAT_RES.ok;
    endproperty
    a_miss: assert property (p_miss) else $error("miss with translation");

    property p_user_ok;
        XLAT_REQ.valid && XLAT_REQ.mode == TAT_USER && XLAT_REQ.va[39:31] == 9'h000
            |=> XLAT_RES.done && !XLAT_RES.addr_err;
    endproperty
    a_user_ok: assert property (p_user_ok) else $error("user low half refused");

    property p_user64;
        XLAT_REQ.valid && XLAT_REQ.mode == TAT_USER && s_r.addr64
            |=> XLAT_RES.done && !XLAT_RES.addr_err;
    endproperty
    a_user64: assert property (p_user64) else $error("wide user space refused");

    property p_hi_err;
        XLAT_REQ.valid && (XLAT_REQ.mode == TAT_KERNEL || XLAT_REQ.mode == TAT_SUPER)
            && XLAT_REQ.va[39:32] != 8'h00 |=> XLAT_RES.addr_err;
    endproperty
    a_hi_err: assert property (p_hi_err) else $error("address above 4 GB allowed");

    property p_sup_low;
        XLAT_REQ.valid && XLAT_REQ.mode == TAT_SUPER && XLAT_REQ.va[39:31] == 9'h000
            |=> !XLAT_RES.addr_err;
    endproperty
    a_sup_low: assert property (p_sup_low) else $error("supervisor low half refused");

    property p_store_d;
        XLAT_RES.ok && $past(XLAT_REQ.valid) && $past(XLAT_REQ.store) && $past(r_mapped)
            |-> $past(slo.d);
    endproperty
    a_store_d: assert property (p_store_d) else $error("store to clean page");

    property p_use_valid;
        XLAT_RES.ok && $past(XLAT_REQ.valid) && $past(r_mapped)
            |-> $past(found) && $past(slo.v);
    endproperty
    a_use_valid: assert property (p_use_valid) else $error("invalid page used");

    property p_space_id;
        XLAT_RES.ok && $past(XLAT_REQ.valid) && $past(r_mapped)
            |-> ($past(se.process_space_id) == $past(s_r.process_space_id)) || ($past(se.lo_e.g) && $past(se.lo_o.g));
    endproperty
    a_space_id: assert property (p_space_id) else $error("foreign space id hit");

    property p_frame;
        XLAT_RES.ok && $past(XLAT_REQ.valid) && $past(r_mapped)
            |-> XLAT_RES.pa[35:24] == $past(slo.page_frame_number[23:12]) && XLAT_RES.cca == $past(slo.cca);
    endproperty
    a_frame: assert property (p_frame) else $error("frame or attribute lost");

    property p_lo_rsvd;
        APB_RSP.pready && !$past(APB_REQ.pwrite)
            && ($past(APB_REQ.paddr) == TAT_OFF_LOE || $past(APB_REQ.paddr) == TAT_OFF_LOO)
            |-> APB_RSP.prdata[31:30] == 2'b00;
    endproperty
    a_lo_rsvd: assert property (p_lo_rsvd) else $error("low word reserved bits set");

    property p_cv_hit;
        XLAT_RES.ok && $past(r_mapped);
    endproperty
    c_cv_hit: cover property (p_cv_hit);

    property p_cv_miss;
        XLAT_RES.miss;
    endproperty
    c_cv_miss: cover property (p_cv_miss);

    property p_cv_wprot;
        XLAT_RES.wprot;
    endproperty
    c_cv_wprot: cover property (p_cv_wprot);

    property p_cv_probe;
        access && APB_REQ.pwrite && APB_REQ.paddr == TAT_OFF_CMD && pfound;
    endproperty
    c_cv_probe: cover property (p_cv_probe);
endmodule : tat_top

/* File: bench/tat_pipe_model.sv */
`timescale 1ns/1ps
module tat_pipe_model
    import tat_pkg::*;
(
    input  wire logic              clk,
    output tat_pkg::tat_req_t      req,
    input  wire tat_pkg::tat_res_t res
);
    initial req = '0;

    // idle cycles carry a flipped address so a stale value never looks current
    task automatic issue(input tat_mode_t m, input logic st, input logic [39:0] va,
                         output tat_res_t r);
        @(posedge clk);
        req <= '{valid: 1'b1, store: st, mode: m, va: va};
        @(posedge clk);
        req <= '{valid: 1'b0, store: ~st, mode: m, va: ~va};
        #1 r = res;
    endtask : issue
endmodule : tat_pipe_model

/* File: bench/test_tat_top.sv */
`timescale 1ns/1ps
module test_tat_top;
    import tat_pkg::*;
    localparam logic [3:0]  K_ERR = 4'h8;
    localparam logic [3:0]  K_MISS = 4'h4;
    localparam logic [3:0]  K_WP = 4'h2;
    localparam logic [3:0]  K_OK = 4'h1;
    localparam logic [31:0] LO_E = 32'h02AF379E;
    localparam logic [31:0] LO_O = 32'h0048D152;
    logic         SYS_CLK;
    logic         SYS_RST;
    tat_apb_req_t apb_req;
    tat_apb_rsp_t apb_rsp;
    tat_req_t     xreq;
    tat_res_t     xres;
    int           error_cnt = 0;
    int           tests_run = 0;

    tat_top i_dut (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .APB_REQ(apb_req),
                   .APB_RSP(apb_rsp), .XLAT_REQ(xreq), .XLAT_RES(xres));
    tat_pipe_model i_pipe (.clk(SYS_CLK), .req(xreq), .res(xres));

    initial
    begin
        SYS_CLK = 1'b0;
        forever #2 SYS_CLK = ~SYS_CLK;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : results

    task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
        tests_run++;
        if (g !== e)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // no latency assumed; the access phase lasts until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        @(posedge SYS_CLK);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge SYS_CLK);
        apb_req.penable <= 1'b1;
        do
            @(posedge SYS_CLK);
        while (apb_rsp.pready !== 1'b1);
        q = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic xe = 1'b0);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
        chk("write error", {39'h0, xe}, {39'h0, e});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe = 1'b0);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk("read data", {8'h0, x}, {8'h0, q});
        chk("read error", {39'h0, xe}, {39'h0, e});
    endtask : rd

    task automatic load(input logic [31:0] i, hi, le, lo, mk);
        wr(TAT_OFF_HI, hi);
        wr(TAT_OFF_LOE, le);
        wr(TAT_OFF_LOO, lo);
        wr(TAT_OFF_MASK, mk);
        wr(TAT_OFF_IDX, i);
        wr(TAT_OFF_CMD, {30'h0, TAT_CMD_WR});
    endtask : load

    task automatic xl(input tat_mode_t m, input logic st, input logic [39:0] va,
                      input logic [3:0] k, input logic [35:0] pa, input logic [2:0] c);
        tat_res_t r;
        i_pipe.issue(m, st, va, r);
        chk("done", 40'h1, {39'h0, r.done});
        chk("result kind", {36'h0, k}, {36'h0, r.addr_err, r.miss, r.wprot, r.ok});
        chk("phys addr", {4'h0, pa}, {4'h0, r.pa});
        chk("cache attr", {37'h0, c}, {37'h0, r.cca});
    endtask : xl

    task automatic sc_regs();
        rd(TAT_OFF_HI, 32'h0);
        wr(TAT_OFF_HI, 32'hFFFFE0FF);
        rd(TAT_OFF_HI, 32'hFFFFE0FF);
        wr(TAT_OFF_LOE, 32'h3FFFFFFF);
        rd(TAT_OFF_LOE, 32'h3FFFFFFF);
        wr(TAT_OFF_MASK, 32'h01FFE000);
        rd(TAT_OFF_MASK, 32'h01FFE000);
        rd(TAT_OFF_CMD, 32'h0);
        wr(8'h1C, 32'hFFFFFFFF, 1'b1);
        rd(8'h1C, 32'h0, 1'b1);
        rd(8'h02, 32'h0, 1'b1);
    endtask : sc_regs

    // last slot used so an off-by-one in the entry count shows up
    task automatic sc_xlat();
        load(47, 32'h00400005, LO_E, LO_O, 0);
        xl(TAT_USER, 1'b0, 40'h00400123, K_OK, 36'h0ABCDE123, 3'h3);
        xl(TAT_USER, 1'b0, 40'h00401123, K_OK, 36'h012345123, 3'h2);
        xl(TAT_USER, 1'b1, 40'h00401123, K_WP, 36'h0, 3'h0);
        xl(TAT_USER, 1'b1, 40'h00400123, K_OK, 36'h0ABCDE123, 3'h3);
        wr(TAT_OFF_HI, 32'h00400006);
        xl(TAT_USER, 1'b0, 40'h00400123, K_MISS, 36'h0, 3'h0);
    endtask : sc_xlat

    task automatic sc_attr();
        load(0, 32'h00800005, LO_E | 32'h1, LO_O | 32'h1, 0);
        load(1, 32'h01000005, LO_E | 32'h1, LO_O, 0);
        wr(TAT_OFF_HI, 32'h00000009);
        xl(TAT_USER, 1'b0, 40'h00800010, K_OK, 36'h0ABCDE010, 3'h3);
        xl(TAT_USER, 1'b0, 40'h01000010, K_MISS, 36'h0, 3'h0);
        load(2, 32'h01400009, LO_E & ~32'h2, LO_O, 0);
        xl(TAT_USER, 1'b0, 40'h01400000, K_MISS, 36'h0, 3'h0);
        xl(TAT_USER, 1'b0, 40'h01401000, K_OK, 36'h012345000, 3'h2);
    endtask : sc_attr

    task automatic sc_mask();
        load(3, 32'h02000009, LO_E, LO_O, 32'h00006000);
        xl(TAT_USER, 1'b0, 40'h02006ABC, K_OK, 36'h012346ABC, 3'h2);
        xl(TAT_USER, 1'b0, 40'h02002ABC, K_OK, 36'h0ABCDEABC, 3'h3);
        wr(TAT_OFF_CMD, {30'h0, TAT_CMD_PROBE});
        rd(TAT_OFF_IDX, 32'h00000003);
        wr(TAT_OFF_HI, 32'h03000009);
        wr(TAT_OFF_CMD, {30'h0, TAT_CMD_PROBE});
        rd(TAT_OFF_IDX, 32'h80000003);
        wr(TAT_OFF_IDX, 32'd47);
        wr(TAT_OFF_CMD, {30'h0, TAT_CMD_RD});
        rd(TAT_OFF_LOO, LO_O);
        rd(TAT_OFF_HI, 32'h00400005);
    endtask : sc_mask

    task automatic sc_regions();
        xl(TAT_USER, 1'b0, 40'h0080000000, K_ERR, 36'h0, 3'h0);
        xl(TAT_USER, 1'b0, 40'h007FFFF000, K_MISS, 36'h0, 3'h0);
        xl(TAT_SUPER, 1'b0, 40'h0080000000, K_ERR, 36'h0, 3'h0);
        xl(TAT_SUPER, 1'b0, 40'h00A0000000, K_ERR, 36'h0, 3'h0);
        xl(TAT_SUPER, 1'b0, 40'h00C0000000, K_MISS, 36'h0, 3'h0);
        xl(TAT_SUPER, 1'b0, 40'h00E0000000, K_ERR, 36'h0, 3'h0);
        xl(TAT_KERNEL, 1'b1, 40'h0080001234, K_OK, 36'h000001234, 3'h3);
        xl(TAT_KERNEL, 1'b1, 40'h00BFFFFFFC, K_OK, 36'h01FFFFFFC, 3'h2);
        xl(TAT_KERNEL, 1'b0, 40'h00E0000000, K_MISS, 36'h0, 3'h0);
        xl(TAT_KERNEL, 1'b0, 40'h0100000000, K_ERR, 36'h0, 3'h0);
        xl(TAT_USER, 1'b0, 40'h0100000000, K_ERR, 36'h0, 3'h0);
        wr(TAT_OFF_CTRL, 32'h1);
        rd(TAT_OFF_CTRL, 32'h1);
        xl(TAT_USER, 1'b0, 40'h0100000000, K_MISS, 36'h0, 3'h0);
    endtask : sc_regions

    // whole run is a few hundred cycles; this bound only trips on a hang
    initial
    begin
        repeat (20000) @(posedge SYS_CLK);
        error_cnt++;
        results();
    end

    initial
    begin
        SYS_RST = 1'b1;
        apb_req = '0;
        repeat (2) @(posedge SYS_CLK);
        SYS_RST <= 1'b0;
        sc_regs();
        sc_xlat();
        sc_attr();
        sc_mask();
        sc_regions();
        results();
    end
endmodule : test_tat_top
